/* hw/tld_cfg.svh */
// register offsets, field positions, reset values and timing counts
`ifndef TLD_CFG_SVH
`define TLD_CFG_SVH
`define TLD_LINK_STRIDE   12'h100
`define TLD_REG_SOFT_RST  12'h002
`define TLD_REG_CFG1      12'h023
`define TLD_REG_CFG2      12'h024
`define TLD_REG_CFG3      12'h025
`define TLD_REG_CFG4      12'h026
`define TLD_REG_TERM      12'h032
`define TLD_REG_IE0       12'h033
`define TLD_REG_IE1       12'h034
`define TLD_REG_EDGE      12'h035
`define TLD_REG_LSTAT0    12'h036
`define TLD_REG_IFLAG0    12'h03A
`define TLD_REG_IFLAG1    12'h03B
`define TLD_REG_TIMING    12'h070
`define TLD_BIT_LINK_DIS  4
`define TLD_BIT_MON_EN    6
`define TLD_BIT_CLK_SRC   0
`define TLD_BIT_CLK_MSTR  1
`define TLD_BIT_REM_LOOP  2
`define TLD_BIT_TX_PDN    3
`define TLD_BIT_E1_MODE   3
`define TLD_BIT_TERM_EXT  2
`define TLD_BIT_DF        0
`define TLD_BIT_DAC       0
`define TLD_RST_CFG1      8'h10
`define TLD_RST_CFG2      8'h00
`define TLD_RST_ZERO      8'h00
`define TLD_CLK_NS        25
`define TLD_T1_UI_NS      648
`define TLD_E1_UI_NS      488
`define TLD_BP_LOST_UI    7'd72
`define TLD_DUTY_MIN_PCT  30
`define TLD_DUTY_MAX_PCT  70
`define TLD_OSC_STUCK     8'hFF
`endif

/* hw/tld_pkg.sv */
// types shared by the tx line driver control block
package tld_pkg;
  typedef logic [1:0][7:0] tld_reg_pair_t;
  typedef struct packed {
    logic [2:0]       gdd_sync;
    logic             gdd;
    logic [2:0]       osc_sync;
    logic             osc_st;
    logic [7:0]       osc_hi;
    logic [7:0]       osc_lo;
    logic [7:0]       osc_hi_last;
    logic             osc_ok;
    logic [1:0][2:0]  bp_sync;
    logic [1:0]       bp_st;
    logic [1:0][4:0]  line_div;
    logic [1:0][6:0]  bp_idle;
    logic [1:0]       bp_lost;
    tld_reg_pair_t    cfg1;
    tld_reg_pair_t    cfg2;
    tld_reg_pair_t    cfg3;
    tld_reg_pair_t    cfg4;
    tld_reg_pair_t    term;
    tld_reg_pair_t    ie0;
    tld_reg_pair_t    ie1;
    tld_reg_pair_t    edge_sel;
    tld_reg_pair_t    timing;
    logic [1:0]       fail_st;
    logic [1:0]       fail_flag;
    logic [1:0]       ovf_flag;
    logic [7:0]       rdata;
    logic             irq;
    logic [1:0]       oe_n;
    logic [1:0]       out_p;
    logic [1:0]       out_n;
    logic [1:0]       prot_en;
    logic [1:0][5:0]  scale;
    logic [1:0]       int_term_en;
    logic [1:0][1:0]  term_sel;
  } tld_state_s;
endpackage

/* hw/tld_line_driver_ctrl.sv */
// transmit line driver control for two links: high-z, driver failure, overflow, termination
//
// Contract
// (R1) software loads scale 000100 for -22.5 dB
// (R2) pulse overlap overflow sets amplitude-overflow flag
// (R3) irq when overflow flag and enable set
// (R4) global disable pin high: both drivers high-z
// (R5) oscillator stuck or bad duty: high-z
// (R6) any reset leaves both drivers high-z
// (R7) per-link disable bit 1: link high-z
// (R8) master mode, recovered clock lost: high-z
// (R9) slave mode, 72 idle UIs: high-z
// (R10) no backplane-loss high-z in remote loopback
// (R11) transmit power down: link high-z
// (R12) high-z applied at once, no boundary wait
// (R13) short protection only while monitor enabled
// (R14) overcurrent shows in driver-failure status
// (R15) edge select: rising or any edge flags
// (R16) irq when failure flag and enable set
// (R17) T1/J1: internal termination only, two bits
// (R18) E1, select bit 2 zero: internal on
// (R19) E1, select bit 2 one: internal off
// (R20) software codes 000/001/010/011, 1XX external
// (R21) link high-z is OR of conditions
// (R22) flags stick until software clears them
//
// Our own choice: strobed register access.
`timescale 1ns/10ps
`include "tld_cfg.svh"

module tld_line_driver_ctrl (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic [11:0] reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  input  wire logic        global_driver_disable_pin,
  input  wire logic        oscillator_input,
  input  wire logic [1:0]  backplane_clk,
  input  wire logic [1:0]  recovered_clk_lost,
  input  wire logic [1:0]  driver_overcurrent,
  input  wire logic [1:0]  amplitude_overflow_event,
  input  wire logic [1:0]  tx_pulse_pos,
  input  wire logic [1:0]  tx_pulse_neg,
  output logic      [1:0]  line_out_positive,
  output logic      [1:0]  line_out_negative,
  output logic      [1:0]  line_out_oe_n,
  output logic      [1:0]  short_protect_en,
  output logic      [11:0] pulse_scale_field,
  output logic      [1:0]  internal_term_en,
  output logic      [3:0]  internal_term_sel,
  output logic             irq
);

  // line-rate tick spacing in system clocks, rounded down
  localparam logic [4:0] T1_UI_CYC = 5'(`TLD_T1_UI_NS / `TLD_CLK_NS);
  localparam logic [4:0] E1_UI_CYC = 5'(`TLD_E1_UI_NS / `TLD_CLK_NS);

  tld_pkg::tld_state_s s;
  tld_pkg::tld_state_s next_s;

  ////////////////////////////////////////////////////////////////////////////
  // reset image; disable bit resets to 1 so drivers start high-z
  function automatic tld_pkg::tld_state_s reset_state();
    tld_pkg::tld_state_s r;
    r = '0;
    r.cfg1 = {2{`TLD_RST_CFG1}}; // see (R6)
    r.cfg2 = {2{`TLD_RST_CFG2}};
    r.oe_n = 2'h3;               // see (R6)
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    logic [11:0] loff;
    logic        lsel;
    logic        addr_ok;
    logic [7:0]  rd;
    logic        hiz;
    logic        ser_flt;
    logic        tick;
    logic        df_now;
    logic        df_edge;
    logic        osc_rise;
    logic        osc_fall;
    int unsigned period;
    int unsigned hi_pct;
    logic        irq_any;
    loff     = {4'h0, reg_addr[7:0]};
    lsel     = reg_addr[8];
    addr_ok  = (reg_addr[11:9] == 3'h0);
    rd       = 8'h00;
    hiz      = 1'b0;
    ser_flt  = 1'b0;
    tick     = 1'b0;
    df_now   = 1'b0;
    df_edge  = 1'b0;
    osc_rise = 1'b0;
    osc_fall = 1'b0;
    period   = 0;
    hi_pct   = 0;
    irq_any  = 1'b0;
    next_s   = s;

    // global disable pin: three stages, accept when last two agree
    next_s.gdd_sync = {s.gdd_sync[1:0], global_driver_disable_pin};
    if (s.gdd_sync[1] == s.gdd_sync[2]) begin
      next_s.gdd = s.gdd_sync[2];
    end

    // oscillator presence: width of each high and low phase in clocks
    next_s.osc_sync = {s.osc_sync[1:0], oscillator_input};
    if (s.osc_sync[1] == s.osc_sync[2]) begin
      next_s.osc_st = s.osc_sync[2];
      osc_rise = s.osc_sync[2] & ~s.osc_st;
      osc_fall = ~s.osc_sync[2] & s.osc_st;
    end
    if (osc_rise) begin
      // a period ends here: judge its duty cycle
      period = int'(s.osc_hi_last) + int'(s.osc_lo);
      hi_pct = int'(s.osc_hi_last) * 100;
      next_s.osc_ok = (hi_pct >= period * `TLD_DUTY_MIN_PCT) &&
                      (hi_pct <= period * `TLD_DUTY_MAX_PCT) &&
                      (s.osc_lo != `TLD_OSC_STUCK) &&
                      (s.osc_hi_last != `TLD_OSC_STUCK); // see (R5)
      next_s.osc_hi = 8'h01;
    end else if (osc_fall) begin
      next_s.osc_hi_last = s.osc_hi;
      next_s.osc_lo      = 8'h01;
    end else if (s.osc_st) begin
      if (s.osc_hi != `TLD_OSC_STUCK) begin
        next_s.osc_hi = s.osc_hi + 8'h01;
      end
    end else begin
      if (s.osc_lo != `TLD_OSC_STUCK) begin
        next_s.osc_lo = s.osc_lo + 8'h01;
      end
    end
    // stuck at either level drops the oscillator at once
    if (s.osc_hi == `TLD_OSC_STUCK || s.osc_lo == `TLD_OSC_STUCK) begin
      next_s.osc_ok = 1'b0; // see (R5)
    end

    // per-link clock watch, failure detect and pin drive
    for (int i = 0; i < 2; i++) begin
      // line-rate tick from a divider; rate follows the link's mode
      tick = 1'b0;
      if (s.term[i][`TLD_BIT_E1_MODE]) begin
        tick = (s.line_div[i] >= E1_UI_CYC - 5'd1);
      end else begin
        tick = (s.line_div[i] >= T1_UI_CYC - 5'd1);
      end
      next_s.line_div[i] = tick ? 5'd0 : s.line_div[i] + 5'd1;

      // backplane clock: count idle line UIs, lost past 72
      next_s.bp_sync[i] = {s.bp_sync[i][1:0], backplane_clk[i]};
      if (s.bp_sync[i][1] == s.bp_sync[i][2] && s.bp_sync[i][2] != s.bp_st[i]) begin
        next_s.bp_st[i]   = s.bp_sync[i][2];
        next_s.bp_idle[i] = 7'd0;
        next_s.bp_lost[i] = 1'b0;
      end else if (tick) begin
        if (s.bp_idle[i] != 7'h7F) begin
          next_s.bp_idle[i] = s.bp_idle[i] + 7'd1;
        end
        if (s.bp_idle[i] >= `TLD_BP_LOST_UI) begin
          next_s.bp_lost[i] = 1'b1; // see (R9)
        end
      end

      // clock source fault depends on master/slave and source bit
      ser_flt = 1'b0;
      if (s.timing[i][`TLD_BIT_CLK_MSTR] && s.timing[i][`TLD_BIT_CLK_SRC]) begin
        ser_flt = recovered_clk_lost[i]; // see (R8)
      end else if (!s.timing[i][`TLD_BIT_CLK_MSTR] && !s.timing[i][`TLD_BIT_CLK_SRC]) begin
        ser_flt = s.bp_lost[i] & ~s.timing[i][`TLD_BIT_REM_LOOP]; // see (R9) see (R10)
      end

      // every high-z cause ORed together
      hiz = s.gdd                                 // see (R4)
          | ~s.osc_ok                             // see (R5)
          | s.cfg1[i][`TLD_BIT_LINK_DIS]          // see (R7)
          | ser_flt
          | s.timing[i][`TLD_BIT_TX_PDN];         // see (R11) see (R21)
      // enable drops on the very next edge, data path not waited on
      next_s.oe_n[i]  = hiz;                      // see (R12)
      next_s.out_p[i] = tx_pulse_pos[i] & ~hiz;
      next_s.out_n[i] = tx_pulse_neg[i] & ~hiz;

      // short protection and failure status gated by monitor enable
      next_s.prot_en[i] = s.cfg3[i][`TLD_BIT_MON_EN];                         // see (R13)
      df_now = driver_overcurrent[i] & s.cfg3[i][`TLD_BIT_MON_EN];
      next_s.fail_st[i] = df_now;                                             // see (R14)
      df_edge = s.edge_sel[i][`TLD_BIT_DF] ? (df_now != s.fail_st[i])
                                           : (df_now & ~s.fail_st[i]);       // see (R15)

      // termination: T1/J1 always internal, E1 per bit 2
      next_s.term_sel[i] = s.term[i][1:0];                                    // see (R17)
      if (s.term[i][`TLD_BIT_E1_MODE]) begin
        next_s.int_term_en[i] = ~s.term[i][`TLD_BIT_TERM_EXT];                // see (R18) see (R19)
      end else begin
        next_s.int_term_en[i] = 1'b1;                                         // see (R17)
      end
      next_s.scale[i] = s.cfg2[i][5:0];

      // sticky flags: write 1 clears, a new event in the same cycle wins
      if (reg_wr && addr_ok && lsel == 1'(i) && loff == `TLD_REG_IFLAG0 &&
          reg_wdata[`TLD_BIT_DF]) begin
        next_s.fail_flag[i] = 1'b0;
      end
      if (df_edge) begin
        next_s.fail_flag[i] = 1'b1;                                           // see (R15) see (R22)
      end
      if (reg_wr && addr_ok && lsel == 1'(i) && loff == `TLD_REG_IFLAG1 &&
          reg_wdata[`TLD_BIT_DAC]) begin
        next_s.ovf_flag[i] = 1'b0;
      end
      if (amplitude_overflow_event[i]) begin
        next_s.ovf_flag[i] = 1'b1;                                            // see (R2) see (R22)
      end

      // interrupt sources
      irq_any = irq_any
              | (s.ovf_flag[i] & s.ie1[i][`TLD_BIT_DAC])                      // see (R3)
              | (s.fail_flag[i] & s.ie0[i][`TLD_BIT_DF]);                     // see (R16)
    end
    next_s.irq = irq_any;

    // register writes; scale field loaded as written by software
    if (reg_wr && addr_ok) begin
      unique case (loff)
        `TLD_REG_CFG1:   next_s.cfg1[lsel]     = reg_wdata;                   // see (R7)
        `TLD_REG_CFG2:   next_s.cfg2[lsel]     = reg_wdata;                   // see (R1)
        `TLD_REG_CFG3:   next_s.cfg3[lsel]     = reg_wdata;
        `TLD_REG_CFG4:   next_s.cfg4[lsel]     = reg_wdata;
        `TLD_REG_TERM:   next_s.term[lsel]     = reg_wdata;                   // see (R20)
        `TLD_REG_IE0:    next_s.ie0[lsel]      = reg_wdata;
        `TLD_REG_IE1:    next_s.ie1[lsel]      = reg_wdata;
        `TLD_REG_EDGE:   next_s.edge_sel[lsel] = reg_wdata;
        `TLD_REG_TIMING: next_s.timing[lsel]   = reg_wdata;
        default: ;
      endcase
    end

    // read mux; unmapped addresses read zero
    if (addr_ok) begin
      unique case (loff)
        `TLD_REG_CFG1:   rd = s.cfg1[lsel];
        `TLD_REG_CFG2:   rd = s.cfg2[lsel];
        `TLD_REG_CFG3:   rd = s.cfg3[lsel];
        `TLD_REG_CFG4:   rd = s.cfg4[lsel];
        `TLD_REG_TERM:   rd = s.term[lsel];
        `TLD_REG_IE0:    rd = s.ie0[lsel];
        `TLD_REG_IE1:    rd = s.ie1[lsel];
        `TLD_REG_EDGE:   rd = s.edge_sel[lsel];
        `TLD_REG_LSTAT0: rd = {7'h00, s.fail_st[lsel]};
        `TLD_REG_IFLAG0: rd = {7'h00, s.fail_flag[lsel]};
        `TLD_REG_IFLAG1: rd = {7'h00, s.ovf_flag[lsel]};
        `TLD_REG_TIMING: rd = s.timing[lsel];
        default:         rd = 8'h00;
      endcase
    end
    next_s.rdata = reg_rd ? rd : 8'h00;

    // software reset: whole state back to the reset image
    if (reg_wr && reg_addr == `TLD_REG_SOFT_RST && reg_wdata[0]) begin
      next_s = reset_state(); // see (R6)
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s <= reset_state(); // see (R6)
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, each straight from the state register
  assign reg_rdata         = s.rdata;
  assign line_out_positive = s.out_p;
  assign line_out_negative = s.out_n;
  assign line_out_oe_n     = s.oe_n;
  assign short_protect_en  = s.prot_en;
  assign pulse_scale_field = {s.scale[1], s.scale[0]};
  assign internal_term_en  = s.int_term_en;
  assign internal_term_sel = {s.term_sel[1], s.term_sel[0]};
  assign irq               = s.irq;

endmodule

/* tb/tld_line_driver_ctrl_assertions.sv */
// port-level checks for the tx line driver control block
`timescale 1ns/10ps
module tld_ldc_checker (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic [11:0] reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  input wire logic        global_driver_disable_pin,
  input wire logic        oscillator_input,
  input wire logic [1:0]  tx_pulse_pos,
  input wire logic [1:0]  line_out_positive,
  input wire logic [1:0]  line_out_oe_n,
  input wire logic [1:0]  short_protect_en,
  input wire logic [11:0] pulse_scale_field,
  input wire logic [1:0]  internal_term_en
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic [8:0] same_cnt;
  logic       osc_q;
  ////////////////////////////////////////
  // cycles the oscillator level has not moved, saturating so it never wraps
  always_ff @(posedge sys_clk) begin
    osc_q <= oscillator_input;
    if (rst || oscillator_input != osc_q) same_cnt <= 9'h000;
    else if (same_cnt != 9'h1FF) same_cnt <= same_cnt + 9'h001;
  end
  ////////////////////////////////////////
  // reset itself must not be masked, so no disable here
  chk_rst_hiz: assert property (disable iff (1'b0) rst |=> line_out_oe_n == 2'h3)
    else $error("drivers not off in reset");
  chk_release_hiz: assert property ($fell(rst) |-> line_out_oe_n == 2'h3 [*3])
    else $error("drivers on right after reset");
  chk_pin_hiz: assert property (global_driver_disable_pin [*6] |=> line_out_oe_n == 2'h3)
    else $error("drivers on while disable pin high");
  chk_osc_hiz: assert property (same_cnt >= 9'h12C |-> line_out_oe_n == 2'h3)
    else $error("drivers on with stuck oscillator");
  chk_gate_zero: assert property ((line_out_positive & line_out_oe_n) == 2'h0)
    else $error("data on a high-z pair");
  chk_data_pass: assert property (!line_out_oe_n[0] |-> line_out_positive[0] == $past(tx_pulse_pos[0]))
    else $error("driven data lost");
  chk_link_off: assert property (reg_wr && reg_addr == 12'h023 && reg_wdata[4] |=> ##1 line_out_oe_n[0])
    else $error("disable bit ignored");
  chk_scale_load: assert property (reg_wr && reg_addr == 12'h024 |=> ##1
    pulse_scale_field[5:0] == $past(reg_wdata[5:0], 2))
    else $error("scale field wrong");
  chk_mon_enable: assert property (reg_wr && reg_addr == 12'h025 |=> ##1
    short_protect_en[0] == $past(reg_wdata[6], 2))
    else $error("protection enable wrong");
  chk_term_ext: assert property (reg_wr && reg_addr == 12'h032 && reg_wdata[3:2] == 2'h3 |=> ##1
    !internal_term_en[0])
    else $error("internal termination on in external mode");
  chk_term_t1: assert property (reg_wr && reg_addr == 12'h032 && !reg_wdata[3] |=> ##1
    internal_term_en[0])
    else $error("internal termination off in t1 mode");
  chk_rd_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside read slot");
  chk_rd_unmapped: assert property (reg_rd && reg_addr[11:9] != 3'h0 |=> reg_rdata == 8'h00)
    else $error("bad address read not zero");
endmodule

/* tb/tld_cable_model.sv */
// cable side: a shorted pair draws overcurrent only while it is driven
`timescale 1ns/10ps
module tld_cable_model (
  input  wire logic       sys_clk,
  input  wire logic [1:0] line_out_positive,
  input  wire logic [1:0] line_out_negative,
  input  wire logic [1:0] line_out_oe_n,
  input  wire logic [1:0] short_cmd,
  output logic      [1:0] driver_overcurrent = 2'h0
);
  // a high-z pair carries no current, so a short there stays silent
  always @(posedge sys_clk) begin
    driver_overcurrent <= short_cmd & ~line_out_oe_n & (line_out_positive | line_out_negative);
  end
endmodule

/* tb/tld_line_driver_ctrl_test.sv */
// self-checking bench for the tx line driver control block
`timescale 1ns/10ps
module tld_line_driver_ctrl_test;
  logic        sys_clk, rst, reg_wr, reg_rd, global_driver_disable_pin, irq;
  logic        oscillator_input;
  logic [11:0] reg_addr, pulse_scale_field;
  logic [7:0]  reg_wdata, reg_rdata;
  logic [1:0]  backplane_clk, recovered_clk_lost, driver_overcurrent, amplitude_overflow_event;
  logic [1:0]  tx_pulse_pos, tx_pulse_neg, line_out_positive, line_out_negative, line_out_oe_n;
  logic [1:0]  short_protect_en, internal_term_en, short_cmd;
  logic [3:0]  internal_term_sel;
  logic [1:0]  osc_mode = 2'h0;
  logic [1:0]  bp_run = 2'h3;
  int          error_cnt = 0;
  int          n_tests = 0;
  tld_line_driver_ctrl uut (.sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .global_driver_disable_pin, .oscillator_input, .backplane_clk, .recovered_clk_lost,
    .driver_overcurrent, .amplitude_overflow_event, .tx_pulse_pos, .tx_pulse_neg,
    .line_out_positive, .line_out_negative, .line_out_oe_n, .short_protect_en,
    .pulse_scale_field, .internal_term_en, .internal_term_sel, .irq);
  tld_cable_model cable (.sys_clk, .line_out_positive, .line_out_negative, .line_out_oe_n,
    .short_cmd, .driver_overcurrent);
  ////////////////////////////////////////
  // 40 MHz clock; oscillator of 10 cycles at 50 %, stuck low, or 20 % duty
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  initial begin
    oscillator_input = 1'b0;
    forever begin
      repeat (osc_mode == 2'h2 ? 8 : 5) @(posedge sys_clk);
      if (osc_mode != 2'h1) oscillator_input <= 1'b1;
      repeat (osc_mode == 2'h2 ? 2 : 5) @(posedge sys_clk);
      oscillator_input <= 1'b0;
    end
  end
  // backplane clocks toggle every 8 cycles while running, stand still when stopped;
  // slower than the sync chain so two stages can agree on each level
  logic [2:0]  bp_div = 3'h0;
  initial backplane_clk = 2'h0;
  always @(posedge sys_clk) begin
    bp_div <= bp_div + 3'h1;
    if (bp_div == 3'h7) backplane_clk <= backplane_clk ^ bp_run;
  end
  ////////////////////////////////////////
  task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [11:0] a, input logic [7:0] exp, input string what);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk(what, {4'h0, exp}, {4'h0, reg_rdata});
  endtask
  task automatic wait_oe(input logic [1:0] exp, input int lim, input string what);
    #1;
    repeat (lim) if (line_out_oe_n !== exp) @(posedge sys_clk) #1;
    chk(what, {10'h0, exp}, {10'h0, line_out_oe_n});
  endtask
  ////////////////////////////////////////
  task automatic t_enable;
    chk("oe after reset", 12'h003, {10'h0, line_out_oe_n});
    rd(12'h023, 8'h10, "cfg1 reset");
    rd(12'h070, 8'h00, "timing reset");
    rd(12'h050, 8'h00, "unmapped");
    rd(12'h223, 8'h00, "bad link");
    wr(12'h023, 8'h00);
    wr(12'h123, 8'h00);
    wait_oe(2'h0, 60, "both driving");
    chk("line data", 12'h003, {10'h0, line_out_positive});
    @(posedge sys_clk);
    tx_pulse_pos <= 2'h2;
    tx_pulse_neg <= 2'h1;
    cyc(2);
    chk("line pos", 12'h002, {10'h0, line_out_positive});
    chk("line neg", 12'h001, {10'h0, line_out_negative});
    wr(12'h023, 8'h10);
    wait_oe(2'h1, 2, "link0 off");
    wr(12'h023, 8'h00);
    wait_oe(2'h0, 2, "link0 on");
    @(posedge sys_clk);
    global_driver_disable_pin <= 1'b1;
    wait_oe(2'h3, 6, "pin off");
    repeat (4) @(posedge sys_clk);
    global_driver_disable_pin <= 1'b0;
    wait_oe(2'h0, 8, "pin on");
    $display("enable and pin done");
  endtask
  task automatic t_osc;
    osc_mode = 2'h1;
    wait_oe(2'h3, 320, "osc stuck");
    cyc(120);
    chk("still off", 12'h003, {10'h0, line_out_oe_n});
    osc_mode = 2'h0;
    wait_oe(2'h0, 60, "osc back");
    osc_mode = 2'h2;
    wait_oe(2'h3, 60, "osc duty");
    osc_mode = 2'h0;
    wait_oe(2'h0, 60, "osc back");
    $display("oscillator done");
  endtask
  task automatic t_clk;
    wr(12'h070, 8'h03);
    recovered_clk_lost <= 2'h1;
    wait_oe(2'h1, 5, "recovered lost");
    wr(12'h070, 8'h00);
    wait_oe(2'h0, 5, "slave mode");
    bp_run <= 2'h2;
    cyc(1700);
    chk("early loss", 12'h000, {10'h0, line_out_oe_n});
    wait_oe(2'h1, 300, "backplane lost");
    wr(12'h070, 8'h04);
    wait_oe(2'h0, 5, "remote loopback");
    @(posedge sys_clk);
    recovered_clk_lost <= 2'h0;
    bp_run <= 2'h3;
    wr(12'h070, 8'h08);
    wait_oe(2'h1, 5, "power down");
    wr(12'h070, 8'h00);
    wait_oe(2'h0, 20, "power up");
    $display("clock loss done");
  endtask
  task automatic t_fail;
    @(posedge sys_clk);
    short_cmd <= 2'h1;
    cyc(4);
    rd(12'h036, 8'h00, "status unmonitored");
    wr(12'h025, 8'h40);
    cyc(4);
    chk("protect", 12'h001, {10'h0, short_protect_en});
    rd(12'h036, 8'h01, "fail status");
    rd(12'h03A, 8'h01, "rise flag");
    wr(12'h033, 8'h01);
    cyc(2);
    chk("fail irq", 12'h001, {11'h0, irq});
    wr(12'h03A, 8'h01);
    cyc(2);
    chk("irq cleared", 12'h000, {11'h0, irq});
    short_cmd <= 2'h0;
    cyc(4);
    rd(12'h03A, 8'h00, "fall ignored");
    wr(12'h035, 8'h01);
    short_cmd <= 2'h1;
    cyc(4);
    wr(12'h03A, 8'h01);
    short_cmd <= 2'h0;
    cyc(4);
    rd(12'h03A, 8'h01, "fall flag");
    wr(12'h033, 8'h00);
    wr(12'h03A, 8'h01);
    @(posedge sys_clk);
    amplitude_overflow_event <= 2'h2;
    @(posedge sys_clk);
    amplitude_overflow_event <= 2'h0;
    rd(12'h13B, 8'h01, "overflow flag");
    chk("irq masked", 12'h000, {11'h0, irq});
    wr(12'h134, 8'h01);
    cyc(2);
    chk("overflow irq", 12'h001, {11'h0, irq});
    wr(12'h13B, 8'h01);
    cyc(2);
    chk("irq cleared", 12'h000, {11'h0, irq});
    $display("failure and overflow done");
  endtask
  task automatic t_term;
    logic [7:0] code [6];
    logic       en;
    code = '{8'h08, 8'h09, 8'h0C, 8'h03, 8'h06, 8'h02};
    foreach (code[k]) begin
      wr(12'h032, code[k]);
      cyc(1);
      en = ~(code[k][3] & code[k][2]);
      chk("term en", {11'h0, en}, {11'h0, internal_term_en[0]});
      if (en) chk("term sel", {10'h0, code[k][1:0]}, {10'h0, internal_term_sel[1:0]});
    end
    wr(12'h024, 8'h04);
    wr(12'h124, 8'h05);
    cyc(1);
    chk("scale", 12'h144, pulse_scale_field);
    wr(12'h002, 8'h01);
    wait_oe(2'h3, 2, "soft reset");
    rd(12'h023, 8'h10, "cfg1 soft");
    $display("termination, scale and soft reset done");
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  ////////////////////////////////////////
  // reset for 8 cycles, then the scenarios in order
  initial begin
    rst = 1'b1;
    {reg_wr, reg_rd, global_driver_disable_pin} = 3'h0;
    reg_addr = 12'h000;
    reg_wdata = 8'h00;
    {recovered_clk_lost, amplitude_overflow_event, short_cmd} = 6'h00;
    tx_pulse_pos = 2'h3;
    tx_pulse_neg = 2'h0;
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    cyc(1);
    t_enable;
    t_osc;
    t_clk;
    t_fail;
    t_term;
    give_verdict;
  end
  // watchdog at about five times the expected run
  initial begin
    #(25 * 12000);
    error_cnt++;
    give_verdict;
  end
endmodule
bind tld_line_driver_ctrl tld_ldc_checker chk_i (.sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata, .global_driver_disable_pin, .oscillator_input, .tx_pulse_pos,
  .line_out_positive, .line_out_oe_n, .short_protect_en, .pulse_scale_field, .internal_term_en);
